// [rtl/compare_unit_regs.svh]
// Register offsets, field positions and reset values of the compare unit
`ifndef COMPARE_UNIT_REGS_SVH
`define COMPARE_UNIT_REGS_SVH

`define ADDR_VALUE_LOW 8'h00
`define ADDR_VALUE_HIGH 8'h04
`define ADDR_CONTROL 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_FORCE 8'h10

`define CTRL_WAVE_LSB 0
`define CTRL_WAVE_MSB 3
`define CTRL_ACTION_LSB 4
`define CTRL_ACTION_MSB 5
`define CTRL_IRQ_EN_BIT 6
`define STATUS_FLAG_BIT 0
`define FORCE_STROBE_BIT 0

`define CONTROL_RESET 8'h00
`define VALUE_RESET 16'h0000

`endif

// [rtl/compare_pkg.sv]
// Types and mode decoding shared by the compare unit modules
package compare_pkg;

   typedef enum logic [2:0] {
      CLS_NORMAL,
      CLS_CLEAR_ON_MATCH,
      CLS_FAST,
      CLS_PHASE,
      CLS_PHASE_FREQ
   } wave_class_e;

   // Mode 13 is reserved; it is treated like normal mode
   function automatic wave_class_e classify(input logic [3:0] wsel);
      case (wsel)
         4'h4, 4'hC: classify = CLS_CLEAR_ON_MATCH;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: classify = CLS_FAST;
         4'h1, 4'h2, 4'h3, 4'hA, 4'hB: classify = CLS_PHASE;
         4'h8, 4'h9: classify = CLS_PHASE_FREQ;
         default: classify = CLS_NORMAL;
      endcase
   endfunction

   function automatic logic is_pwm(input wave_class_e cls);
      is_pwm = (cls == CLS_FAST) || (cls == CLS_PHASE) ||
               (cls == CLS_PHASE_FREQ);
   endfunction

endpackage

// [rtl/wave_if.sv]
// Match events and output state passed between core and wave generator
`timescale 1ns/100ps
`default_nettype none
interface wave_if;
   import compare_pkg::*;
   logic match_ev;
   logic force_ev;
   logic top_ev;
   logic count_down;
   wave_class_e cls;
   logic [1:0] action;
   logic oc;
   modport core (output match_ev, force_ev, top_ev, count_down, cls,
                 action, input oc);
   modport gen (input match_ev, force_ev, top_ev, count_down, cls,
                action, output oc);
endinterface
`default_nettype wire

// [rtl/wave_gen.sv]
// Waveform generator: holds the compare output state
`timescale 1ns/100ps
`default_nettype none
module wave_gen (
   input wire logic sys_clk,
   input wire logic rst,
   wave_if.gen w
);
   import compare_pkg::*;

   logic oc;
   logic next_oc;

   assign w.oc = oc;

   // Action 0 never touches the state; mode changes alone never do either
   always_comb begin
      next_oc = oc;
      if (w.action != 2'b00) begin
         if (w.force_ev) begin
            case (w.action)
               2'b01: next_oc = ~oc;
               2'b10: next_oc = 1'b0;
               default: next_oc = 1'b1;
            endcase
         end else if (w.match_ev) begin
            case (w.cls)
               CLS_NORMAL, CLS_CLEAR_ON_MATCH: begin
                  case (w.action)
                     2'b01: next_oc = ~oc;
                     2'b10: next_oc = 1'b0;
                     default: next_oc = 1'b1;
                  endcase
               end
               CLS_FAST: begin
                  if (w.action == 2'b10)
                     next_oc = 1'b1;
                  else if (w.action == 2'b11)
                     next_oc = 1'b0;
               end
               default: begin
                  if (w.action == 2'b10)
                     next_oc = w.count_down;
                  else if (w.action == 2'b11)
                     next_oc = ~w.count_down;
               end
            endcase
         end else if (w.top_ev && w.cls == CLS_FAST) begin
            if (w.action == 2'b10)
               next_oc = 1'b0;
            else if (w.action == 2'b11)
               next_oc = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         oc <= 1'b0;
      else
         oc <= next_oc;
   end

   chk_no_action_hold: assert property (@(posedge sys_clk)
      disable iff (rst)
      (w.action == 2'b00) |=> $stable(oc))
      else $error("output state changed with action zero");

   chk_toggle_on_match: assert property (@(posedge sys_clk)
      disable iff (rst)
      (w.match_ev && !w.force_ev && w.action == 2'b01 &&
       w.cls == CLS_CLEAR_ON_MATCH) |=> (oc != $past(oc)))
      else $error("output did not toggle on match");

endmodule
`default_nettype wire

// [rtl/compare_unit.sv]
// Timer output compare channel with APB registers and pin override
//
// Contract
// - Compare count with value; flag next tick.
// - Enabled flag interrupts; ack or write-one clears.
// - Generator uses match, mode, action, TOP, BOTTOM; here it gets the count direction instead of BOTTOM.
// - Channel value can serve as counter TOP.
// - Double buffer in PWM modes only.
// - Buffer loads active value at TOP/BOTTOM.
// - CPU reaches buffer or active register.
// - Value changes only by writes; direct high read.
// - High byte first into holding; low loads both.
// - Force updates output, no flag, non-PWM only.
// - Count write blocks match next timer tick.
// - Output state survives waveform mode changes.
// - Action select unbuffered; governs next match.
// - Reset clears output state to zero.
// - Nonzero action overrides port value on pin.
// - Action zero leaves output state unchanged.
// - Action select does not affect capture.
// - Toggle on match in clear-on-match mode.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "compare_unit_regs.svh"
module compare_unit (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_tick,
   input wire logic [15:0] timer_count,
   input wire logic at_top,
   input wire logic at_bottom,
   input wire logic count_down,
   input wire logic count_write,
   input wire logic irq_ack,
   input wire logic port_value,
   input wire logic pin_direction_bit,
   output logic pin_out,
   output logic pin_oe,
   output logic compare_irq,
   output logic compare_flag,
   output logic [15:0] top_value
);
   import compare_pkg::*;

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic [15:0] active_value;
   logic [15:0] buffer_value;
   logic [7:0] temp_high;
   logic [7:0] control;
   logic block;
   logic [15:0] next_active_value;
   logic [15:0] next_buffer_value;
   logic [7:0] next_temp_high;
   logic [7:0] next_control;
   logic next_block;
   logic next_flag;
   logic next_irq;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_pin_out;

   wave_if wif ();

   wave_gen u_gen (
      .sys_clk(sys_clk),
      .rst(rst),
      .w(wif)
   );

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   wave_class_e cls;
   logic pwm;
   logic [1:0] action;
   logic irq_en;
   logic mapped;
   logic wr;
   logic wr_low;
   logic wr_high;
   logic wr_status;
   logic wr_force;
   logic match_ev;
   logic update_pt;
   logic [15:0] cpu_view;

   assign cls = classify(control[`CTRL_WAVE_MSB:`CTRL_WAVE_LSB]);
   assign pwm = is_pwm(cls);
   // Action reaches only the generator and the pin mux, never capture
   assign action = control[`CTRL_ACTION_MSB:`CTRL_ACTION_LSB];
   assign irq_en = control[`CTRL_IRQ_EN_BIT];
   assign mapped = (paddr == `ADDR_VALUE_LOW) ||
                   (paddr == `ADDR_VALUE_HIGH) ||
                   (paddr == `ADDR_CONTROL) ||
                   (paddr == `ADDR_STATUS) ||
                   (paddr == `ADDR_FORCE);
   assign wr = psel && penable && pready && pwrite && mapped;
   assign wr_low = wr && (paddr == `ADDR_VALUE_LOW);
   assign wr_high = wr && (paddr == `ADDR_VALUE_HIGH);
   assign wr_status = wr && (paddr == `ADDR_STATUS);
   assign wr_force = wr && (paddr == `ADDR_FORCE);
   // A count write blocks the comparison until the next tick is spent
   assign match_ev = timer_tick && !block &&
                     (timer_count == active_value);
   // Phase-and-frequency modes reload at BOTTOM, other PWM at TOP
   assign update_pt = timer_tick &&
                      ((cls == CLS_PHASE_FREQ) ? at_bottom : at_top);
   assign cpu_view = pwm ? buffer_value : active_value;

   assign wif.match_ev = match_ev;
   assign wif.force_ev = wr_force && pwdata[`FORCE_STROBE_BIT] &&
                         !pwm;
   assign wif.top_ev = timer_tick && at_top;
   assign wif.count_down = count_down;
   assign wif.cls = cls;
   assign wif.action = action;

   // -------------------------------------------------------------
   // Next values
   // -------------------------------------------------------------
   always_comb begin
      next_control = control;
      next_temp_high = temp_high;
      next_active_value = active_value;
      next_buffer_value = buffer_value;
      if (wr && paddr == `ADDR_CONTROL)
         next_control = pwdata[7:0];
      if (wr_high)
         next_temp_high = pwdata[7:0];
      // Hardware never alters the value itself; only the buffer moves
      if (pwm && update_pt)
         next_active_value = buffer_value;
      if (wr_low) begin
         if (pwm)
            next_buffer_value = {temp_high, pwdata[7:0]};
         else
            next_active_value = {temp_high, pwdata[7:0]};
      end
   end

   always_comb begin
      next_block = block;
      if (count_write)
         next_block = 1'b1;
      else if (timer_tick)
         next_block = 1'b0;
      // The set wins over a clear in the same cycle
      next_flag = compare_flag;
      if (irq_ack || (wr_status && pwdata[`STATUS_FLAG_BIT]))
         next_flag = 1'b0;
      if (match_ev)
         next_flag = 1'b1;
      next_irq = next_flag && irq_en;
      next_pin_out = (action != 2'b00) ? wif.oc : port_value;
   end

   always_comb begin
      next_pready = psel && !penable && !pready;
      next_pslverr = psel && !penable && !mapped;
      next_prdata = prdata;
      if (psel && !penable) begin
         case (paddr)
            `ADDR_VALUE_LOW: next_prdata = {24'h000000, cpu_view[7:0]};
            `ADDR_VALUE_HIGH:
               next_prdata = {24'h000000, cpu_view[15:8]};
            `ADDR_CONTROL: next_prdata = {24'h000000, control};
            `ADDR_STATUS: next_prdata = {31'h00000000, compare_flag};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         control <= `CONTROL_RESET;
         temp_high <= 8'h00;
         active_value <= `VALUE_RESET;
         buffer_value <= `VALUE_RESET;
         block <= 1'b0;
         compare_flag <= 1'b0;
         compare_irq <= 1'b0;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         control <= next_control;
         temp_high <= next_temp_high;
         active_value <= next_active_value;
         buffer_value <= next_buffer_value;
         block <= next_block;
         compare_flag <= next_flag;
         compare_irq <= next_irq;
         pin_out <= next_pin_out;
         pin_oe <= pin_direction_bit;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Counter may use this as its TOP in the modes that ask for it
   assign top_value = active_value;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   chk_flag_on_match: assert property (@(posedge sys_clk)
      disable iff (rst)
      (timer_tick && !block && timer_count == active_value)
      |=> compare_flag)
      else $error("match did not set the flag");

   chk_irq_needs_flag: assert property (@(posedge sys_clk)
      disable iff (rst)
      compare_irq |-> compare_flag)
      else $error("interrupt without flag");

   chk_irq_level: assert property (@(posedge sys_clk)
      disable iff (rst)
      compare_irq == (compare_flag && $past(irq_en)))
      else $error("interrupt does not follow flag and enable");

   chk_ack_clears: assert property (@(posedge sys_clk)
      disable iff (rst)
      (irq_ack && !match_ev) |=> !compare_flag)
      else $error("acknowledge did not clear the flag");

   chk_block_arms: assert property (@(posedge sys_clk)
      disable iff (rst)
      count_write |=> block)
      else $error("count write did not arm the block");

   chk_block_after_write: assert property (@(posedge sys_clk)
      disable iff (rst)
      (count_write && !compare_flag && !irq_ack) ##1
      (timer_tick && !compare_flag)[*1] |=> !compare_flag)
      else $error("match not blocked after count write");

   chk_buffer_steady: assert property (@(posedge sys_clk)
      disable iff (rst)
      (pwm && !update_pt) |=> $stable(active_value))
      else $error("active value moved outside TOP or BOTTOM");

   chk_buffer_load: assert property (@(posedge sys_clk)
      disable iff (rst)
      (pwm && update_pt) |=> (active_value == $past(buffer_value)))
      else $error("buffer not loaded at the update point");

   chk_direct_write: assert property (@(posedge sys_clk)
      disable iff (rst)
      (wr_low && !pwm) |=>
      (active_value == {$past(temp_high), $past(pwdata[7:0])}))
      else $error("low byte write did not load both bytes");

   chk_buffered_write: assert property (@(posedge sys_clk)
      disable iff (rst)
      (wr_low && pwm) |=>
      (buffer_value == {$past(temp_high), $past(pwdata[7:0])}))
      else $error("low byte write did not reach the buffer");

   chk_holding_write: assert property (@(posedge sys_clk)
      disable iff (rst)
      wr_high |=> (temp_high == $past(pwdata[7:0])))
      else $error("high byte write did not reach holding");

   chk_value_hw_steady: assert property (@(posedge sys_clk)
      disable iff (rst)
      (!pwm && !wr_low) |=> $stable(active_value))
      else $error("value changed without a write");

   chk_high_read_direct: assert property (@(posedge sys_clk)
      disable iff (rst)
      (psel && !penable && paddr == `ADDR_VALUE_HIGH) |=>
      (prdata[7:0] == $past(cpu_view[15:8])))
      else $error("high byte read not taken from the register");

   chk_pin_override: assert property (@(posedge sys_clk)
      disable iff (rst)
      (action != 2'b00) |=> (pin_out == $past(wif.oc)))
      else $error("pin not driven by compare output");

   chk_port_passes: assert property (@(posedge sys_clk)
      disable iff (rst)
      (action == 2'b00) |=> (pin_out == $past(port_value)))
      else $error("pin not driven by port value");

   chk_oe_follows: assert property (@(posedge sys_clk)
      disable iff (rst)
      1'b1 |=> (pin_oe == $past(pin_direction_bit)))
      else $error("pin enable does not follow direction bit");

   chk_force_no_flag: assert property (@(posedge sys_clk)
      disable iff (rst)
      (wif.force_ev && !match_ev && !compare_flag) |=> !compare_flag)
      else $error("force set the flag");

   chk_force_reads_zero: assert property (@(posedge sys_clk)
      disable iff (rst)
      (psel && !penable && paddr == `ADDR_FORCE) |=> (prdata == 32'h0))
      else $error("force location read nonzero");

endmodule
`default_nettype wire

// [verif/timer_partner.sv]
// Counter-side model: ticks, count value, extremes and count writes
`timescale 1ns/100ps
`default_nettype none
module timer_partner (
   input wire logic sys_clk,
   output logic timer_tick,
   output logic [15:0] timer_count,
   output logic at_top,
   output logic at_bottom,
   output logic count_down,
   output logic count_write
);
   initial begin
      timer_tick = 1'b0;
      timer_count = 16'h0000;
      at_top = 1'b0;
      at_bottom = 1'b0;
      count_down = 1'b0;
      count_write = 1'b0;
   end
   // One timer clock cycle; count direction set down when at BOTTOM and held after the tick
   task automatic tick(input logic [15:0] cnt, input logic top,
                       input logic bot);
      @(posedge sys_clk);
      timer_count <= cnt;
      at_top <= top;
      at_bottom <= bot;
      count_down <= bot;
      timer_tick <= 1'b1;
      @(posedge sys_clk);
      timer_tick <= 1'b0;
      at_top <= 1'b0;
      at_bottom <= 1'b0;
   endtask
   // Count write followed at once by one timer clock cycle
   task automatic write_tick(input logic [15:0] cnt);
      @(posedge sys_clk);
      count_write <= 1'b1;
      @(posedge sys_clk);
      count_write <= 1'b0;
      timer_count <= cnt;
      count_down <= 1'b0;
      timer_tick <= 1'b1;
      @(posedge sys_clk);
      timer_tick <= 1'b0;
   endtask
   // Count write that never lands on TOP or on BOTTOM
   task automatic cpu_write();
      @(posedge sys_clk);
      count_write <= 1'b1;
      @(posedge sys_clk);
      count_write <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [verif/timer_output_compare_unit_tb.sv]
// Self-checking bench for the output compare unit
`timescale 1ns/100ps
`default_nettype none
`include "compare_unit_regs.svh"
module timer_output_compare_unit_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic irq_ack = 1'b0;
   logic port_value = 1'b0;
   logic pin_direction_bit = 1'b0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, timer_tick, at_top, at_bottom;
   logic count_down, count_write, pin_out, pin_oe, compare_irq;
   logic compare_flag;
   logic [15:0] timer_count, top_value;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;

   always #4 sys_clk = ~sys_clk;

   timer_partner u_cnt (.sys_clk, .timer_tick, .timer_count, .at_top,
      .at_bottom, .count_down, .count_write);
   compare_unit dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .timer_tick, .timer_count,
      .at_top, .at_bottom, .count_down, .count_write, .irq_ack,
      .port_value, .pin_direction_bit, .pin_out, .pin_oe, .compare_irq,
      .compare_flag, .top_value);

   task automatic close_out();
      if (mismatches == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // A hang ends the run as a failure
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", pready, 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("prdata", rdat, exp);
   endtask

   // Flag and pin as {compare_flag, pin_out}, then the active value
   task automatic see(input logic [1:0] fp, input logic [15:0] t);
      repeat (4) @(posedge sys_clk);
      chk("flag_pin", {compare_flag, pin_out}, fp);
      chk("top_value", top_value, t);
   endtask

   // ----------------
   // Scenarios
   // ----------------
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      see(2'b00, 16'h0000);
      rd(`ADDR_CONTROL, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("pslverr", rerr, 1'b1);
      wr(`ADDR_VALUE_HIGH, 32'h12);
      wr(`ADDR_VALUE_LOW, 32'h34);
      see(2'b00, 16'h1234);
      wr(`ADDR_VALUE_HIGH, 32'h56);
      rd(`ADDR_VALUE_HIGH, 32'h12);
      rd(`ADDR_VALUE_LOW, 32'h34);
      wr(`ADDR_CONTROL, 32'h40);
      u_cnt.tick(16'h1233, 1'b0, 1'b0);
      see(2'b00, 16'h1234);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      see(2'b10, 16'h1234);
      chk("compare_irq", compare_irq, 1'b1);
      wr(`ADDR_STATUS, 32'h1);
      see(2'b00, 16'h1234);
      chk("compare_irq", compare_irq, 1'b0);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      @(posedge sys_clk);
      irq_ack <= 1'b1;
      @(posedge sys_clk);
      irq_ack <= 1'b0;
      see(2'b00, 16'h1234);
      // Timer stopped while the count is written
      u_cnt.cpu_write();
      repeat (5) @(posedge sys_clk);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      see(2'b00, 16'h1234);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      see(2'b10, 16'h1234);
      wr(`ADDR_STATUS, 32'h1);
      // Tick right after the count write is still blocked
      u_cnt.write_tick(16'h1234);
      see(2'b00, 16'h1234);
      // Output state is set up before the pin drives
      wr(`ADDR_CONTROL, 32'h30);
      wr(`ADDR_FORCE, 32'h1);
      see(2'b01, 16'h1234);
      pin_direction_bit <= 1'b1;
      rd(`ADDR_FORCE, 32'h0);
      chk("pin_oe", pin_oe, 1'b1);
      wr(`ADDR_CONTROL, 32'h00);
      see(2'b00, 16'h1234);
      port_value <= 1'b1;
      see(2'b01, 16'h1234);
      port_value <= 1'b0;
      wr(`ADDR_CONTROL, 32'h14);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      see(2'b10, 16'h1234);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      see(2'b11, 16'h1234);
      wr(`ADDR_CONTROL, 32'h04);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      wr(`ADDR_CONTROL, 32'h14);
      see(2'b11, 16'h1234);
      wr(`ADDR_CONTROL, 32'h24);
      u_cnt.tick(16'h1234, 1'b0, 1'b0);
      see(2'b10, 16'h1234);
      wr(`ADDR_STATUS, 32'h1);
      wr(`ADDR_CONTROL, 32'h30);
      wr(`ADDR_FORCE, 32'h1);
      wr(`ADDR_CONTROL, 32'h3F);
      see(2'b01, 16'h1234);
      wr(`ADDR_FORCE, 32'h1);
      see(2'b01, 16'h1234);
      wr(`ADDR_VALUE_HIGH, 32'h01);
      wr(`ADDR_VALUE_LOW, 32'h00);
      see(2'b01, 16'h1234);
      rd(`ADDR_VALUE_HIGH, 32'h01);
      u_cnt.tick(16'h0050, 1'b1, 1'b0);
      see(2'b01, 16'h0100);
      u_cnt.tick(16'h0100, 1'b0, 1'b0);
      see(2'b10, 16'h0100);
      wr(`ADDR_CONTROL, 32'h08);
      wr(`ADDR_VALUE_HIGH, 32'h00);
      wr(`ADDR_VALUE_LOW, 32'h80);
      u_cnt.tick(16'h0005, 1'b1, 1'b0);
      see(2'b10, 16'h0100);
      u_cnt.tick(16'h0000, 1'b0, 1'b1);
      see(2'b10, 16'h0080);
      // Phase correct, inverting: set on up-match, clear on down-match
      wr(`ADDR_CONTROL, 32'h31);
      u_cnt.tick(16'h0080, 1'b0, 1'b0);
      see(2'b11, 16'h0080);
      u_cnt.tick(16'h0080, 1'b0, 1'b1);
      see(2'b10, 16'h0080);
      // Fast PWM, non-inverting: set on match, clear at TOP
      wr(`ADDR_CONTROL, 32'h2F);
      u_cnt.tick(16'h0080, 1'b0, 1'b0);
      see(2'b11, 16'h0080);
      u_cnt.tick(16'h0000, 1'b1, 1'b0);
      see(2'b10, 16'h0080);
      close_out();
   end
endmodule
`default_nettype wire
